// *** pkg/sdi12_pkg.sv ***
// shared constants and types for the sdi-12 sensor end
package sdi12_pkg;
   // clock and line timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD = 1200;
   localparam int BIT_CYCLES = CLK_HZ / BAUD;
   localparam int RESP_GAP_US = 8330;
   localparam int GAP_CYCLES = (RESP_GAP_US * (CLK_HZ / 1_000_000) + 0);
   localparam int TIMEOUT_MS = 100;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
   // character framing: start, 7 data, even parity, stop
   localparam int DATA_BITS = 7;
   localparam int FRAME_BITS = 10;
   // characters
   localparam logic [6:0] CH_NUL = 7'h00;
   localparam logic [6:0] CH_LF = 7'h0A;
   localparam logic [6:0] CH_CR = 7'h0D;
   localparam logic [6:0] CH_BANG = 7'h21;
   localparam logic [6:0] CH_QUERY = 7'h3F;
   localparam logic [6:0] CH_ZERO = 7'h30;
   localparam logic [6:0] CH_NINE = 7'h39;
   localparam logic [6:0] CH_UA = 7'h41;
   localparam logic [6:0] CH_UZ = 7'h5A;
   localparam logic [6:0] CH_LA = 7'h61;
   localparam logic [6:0] CH_LZ = 7'h7A;
   localparam logic [6:0] CMD_D = 7'h44;
   localparam logic [6:0] CMD_I = 7'h49;
   localparam logic [6:0] CMD_M = 7'h4D;
   // default address and measure reply text "0011" (wait 001 s, 1 value)
   localparam logic [6:0] DEFAULT_ADDR = 7'h30;
   localparam logic [27:0] MEAS_TEXT = 28'h60C18B1;
   localparam logic [3:0] MEAS_LEN = 4'h4;
   // reply text memory layout
   localparam int MEM_DEPTH = 16;
   localparam logic [3:0] DATA_BASE = 4'h0;
   localparam logic [3:0] IDENT_BASE = 4'h8;
   localparam logic [3:0] REGION_LEN = 4'h8;

   typedef enum logic [1:0] {
      RK_ACK = 2'b00,
      RK_MEAS = 2'b01,
      RK_DATA = 2'b10,
      RK_IDENT = 2'b11
   } respKind_type;

   typedef struct packed {
      logic en;
      logic [3:0] addr;
      logic [6:0] data;
   } memWrite_type;
endpackage : sdi12_pkg

// *** verilog/sdi12_text_mem.sv ***
// small reply text memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module sdi12_text_mem #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // write port
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] store [DEPTH];

   // storage array, no reset
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   // registered read
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= '0;
      end else begin
         rdData <= store[rdAddr];
      end
   end
endmodule : sdi12_text_mem
`default_nettype wire

// *** verilog/sdi12_sensor.sv ***
// sdi-12 smart sensor end of a single data wire
// Notes on behaviour
// - line runs at 1200 baud, seven data bits, even parity, one stop
// - command set and reply forms follow protocol revision 1.3
// - first character of each command is the sensor address
// - addresses are digits, lower-case and upper-case letters only
// - question mark is wildcard address in the address query
// - sensor comes up answering address zero
// - address is followed by one command letter and optional qualifiers
// - exclamation mark ends a command
// - sensor answers every command carrying its address whose bang arrives while the reply sequencer is idle
// - every reply ends with carriage return then line feed
// - any command wakes every probe on the wire
// - only the addressed probe drives a reply
// - woken probes stay active until their own timeout, then sleep
`timescale 1ns/10ps
`default_nettype none
module sdi12_sensor #(
   parameter int BIT_CYCLES = sdi12_pkg::BIT_CYCLES,
   parameter int GAP_CYCLES = sdi12_pkg::GAP_CYCLES,
   parameter int TIMEOUT_CYCLES = sdi12_pkg::TIMEOUT_CYCLES,
   parameter logic [27:0] MEAS_TEXT = sdi12_pkg::MEAS_TEXT
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // data wire
   input wire logic lineIn,
   output logic lineOut,
   output logic lineOe,
   // address setting
   input wire logic addrLoad,
   input wire logic [6:0] addrValue,
   // reply text loading
   input wire sdi12_pkg::memWrite_type textWrite,
   // status
   output logic awake,
   output logic cmdStrobe,
   output logic [6:0] cmdLetter,
   output logic [6:0] myAddr
);
   localparam int CW = $clog2(TIMEOUT_CYCLES + GAP_CYCLES + BIT_CYCLES + 1);

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_BITS = 2'b10,
      RX_STOP = 2'b11
   } rxState_type;

   typedef enum logic [2:0] {
      RS_IDLE = 3'b000,
      RS_GAP = 3'b001,
      RS_HEAD = 3'b010,
      RS_FETCH = 3'b011,
      RS_LOOK = 3'b100,
      RS_CR = 3'b101,
      RS_LF = 3'b110,
      RS_DONE = 3'b111
   } respState_type;

   ////////////////////////////////////////////////////////////////////////////
   // line input synchroniser
   logic syncA;
   logic syncB;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         syncA <= 1'b1;
         syncB <= 1'b1;
      end else begin
         syncA <= lineIn;
         syncB <= syncA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver, parser and wake timer
   rxState_type rxState, next_rxState;
   logic [CW-1:0] rxCnt, next_rxCnt;
   logic [3:0] rxBit, next_rxBit;
   logic [7:0] rxShift, next_rxShift;
   logic [1:0] parsePos, next_parsePos;
   logic [6:0] cmdAddr, next_cmdAddr;
   logic [6:0] qual, next_qual;
   logic [CW-1:0] wakeCnt, next_wakeCnt;
   logic respGo, next_respGo;
   sdi12_pkg::respKind_type respKind, next_respKind;
   logic next_awake;
   logic next_cmdStrobe;
   logic [6:0] next_cmdLetter;
   logic [6:0] next_myAddr;
   logic rxValid;
   logic [6:0] rxChar;
   logic addrOk;
   logic matched;
   logic txActive;
   respState_type respState;

   always_comb begin
      next_rxState = rxState;
      next_rxCnt = rxCnt + 1'b1;
      next_rxBit = rxBit;
      next_rxShift = rxShift;
      next_parsePos = parsePos;
      next_cmdAddr = cmdAddr;
      next_qual = qual;
      next_wakeCnt = wakeCnt;
      next_respGo = 1'b0;
      next_respKind = respKind;
      next_awake = awake;
      next_cmdStrobe = 1'b0;
      next_cmdLetter = cmdLetter;
      next_myAddr = myAddr;
      rxValid = 1'b0;
      rxChar = rxShift[6:0];
      // bit sampling at mid-bit
      case (rxState)
         RX_IDLE: begin
            next_rxCnt = '0;
            if (!syncB) begin
               next_rxState = RX_START;
            end
         end
         RX_START: begin
            if (rxCnt == CW'(BIT_CYCLES / 2)) begin
               next_rxCnt = '0;
               next_rxBit = '0;
               next_rxState = syncB ? RX_IDLE : RX_BITS;
            end
         end
         RX_BITS: begin
            if (rxCnt == CW'(BIT_CYCLES - 1)) begin
               next_rxCnt = '0;
               next_rxShift = {syncB, rxShift[7:1]};
               next_rxBit = rxBit + 1'b1;
               if (rxBit == 4'(sdi12_pkg::DATA_BITS)) begin
                  next_rxState = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rxCnt == CW'(BIT_CYCLES - 1)) begin
               next_rxState = RX_IDLE;
               // own echo and bad parity are dropped
               rxValid = syncB && !(^rxShift) && !txActive;
            end
         end
         default: begin
            next_rxState = RX_IDLE;
         end
      endcase
      // any valid character wakes; quiet for the timeout puts to sleep
      if (rxValid || lineOe) begin
         next_awake = 1'b1;
         next_wakeCnt = '0;
      end else if (awake) begin
         if (wakeCnt == CW'(TIMEOUT_CYCLES - 1)) begin
            next_awake = 1'b0;
            next_parsePos = 2'd0;
         end else begin
            next_wakeCnt = wakeCnt + 1'b1;
         end
      end
      // command parsing
      matched = (cmdAddr == myAddr) || (cmdAddr == sdi12_pkg::CH_QUERY && parsePos == 2'd1);
      if (rxValid) begin
         if (rxChar == sdi12_pkg::CH_BANG) begin
            next_parsePos = 2'd0;
            if (parsePos != 2'd0 && matched && respState == RS_IDLE) begin
               next_respGo = 1'b1;
               next_cmdStrobe = 1'b1;
               if (parsePos == 2'd1) begin
                  next_respKind = sdi12_pkg::RK_ACK;
                  next_cmdLetter = sdi12_pkg::CH_NUL;
               end else if (cmdLetter == sdi12_pkg::CMD_M && parsePos == 2'd2) begin
                  next_respKind = sdi12_pkg::RK_MEAS;
               end else if (cmdLetter == sdi12_pkg::CMD_D && parsePos == 2'd3
                     && qual == sdi12_pkg::CH_ZERO) begin
                  next_respKind = sdi12_pkg::RK_DATA;
               end else if (cmdLetter == sdi12_pkg::CMD_I && parsePos == 2'd2) begin
                  next_respKind = sdi12_pkg::RK_IDENT;
               end else begin
                  next_respKind = sdi12_pkg::RK_ACK;
               end
            end
         end else if (parsePos == 2'd0) begin
            next_cmdAddr = rxChar;
            next_parsePos = 2'd1;
         end else if (parsePos == 2'd1) begin
            next_cmdLetter = rxChar;
            next_parsePos = 2'd2;
         end else if (parsePos == 2'd2) begin
            next_qual = rxChar;
            next_parsePos = 2'd3;
         end
      end
      // address change accepts only legal address characters
      addrOk = (addrValue >= sdi12_pkg::CH_ZERO && addrValue <= sdi12_pkg::CH_NINE)
         || (addrValue >= sdi12_pkg::CH_UA && addrValue <= sdi12_pkg::CH_UZ)
         || (addrValue >= sdi12_pkg::CH_LA && addrValue <= sdi12_pkg::CH_LZ);
      if (addrLoad && addrOk) begin
         next_myAddr = addrValue;
      end
   end

   // receiver and parser registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rxState <= RX_IDLE;
         rxCnt <= '0;
         rxBit <= '0;
         rxShift <= '0;
         parsePos <= 2'd0;
         cmdAddr <= sdi12_pkg::CH_NUL;
         qual <= sdi12_pkg::CH_NUL;
         wakeCnt <= '0;
         respGo <= 1'b0;
         respKind <= sdi12_pkg::RK_ACK;
         awake <= 1'b0;
         cmdStrobe <= 1'b0;
         cmdLetter <= sdi12_pkg::CH_NUL;
         myAddr <= sdi12_pkg::DEFAULT_ADDR;
      end else begin
         rxState <= next_rxState;
         rxCnt <= next_rxCnt;
         rxBit <= next_rxBit;
         rxShift <= next_rxShift;
         parsePos <= next_parsePos;
         cmdAddr <= next_cmdAddr;
         qual <= next_qual;
         wakeCnt <= next_wakeCnt;
         respGo <= next_respGo;
         respKind <= next_respKind;
         awake <= next_awake;
         cmdStrobe <= next_cmdStrobe;
         cmdLetter <= next_cmdLetter;
         myAddr <= next_myAddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reply sequencer and transmitter
   respState_type next_respState;
   logic [CW-1:0] respCnt, next_respCnt;
   logic [3:0] pos, next_pos;
   logic next_txActive;
   logic [9:0] txShift, next_txShift;
   logic [3:0] txBit, next_txBit;
   logic [CW-1:0] txCnt, next_txCnt;
   logic next_lineOut;
   logic next_lineOe;
   logic [3:0] rdAddr;
   logic [6:0] rdData;
   logic [6:0] sendChar;
   logic sendReq;
   logic [6:0] bodyChar;

   assign rdAddr = ((respKind == sdi12_pkg::RK_IDENT) ? sdi12_pkg::IDENT_BASE
      : sdi12_pkg::DATA_BASE) + pos;

   always_comb begin
      next_respState = respState;
      next_respCnt = respCnt;
      next_pos = pos;
      next_txActive = txActive;
      next_txShift = txShift;
      next_txBit = txBit;
      next_txCnt = txCnt;
      next_lineOe = lineOe;
      sendReq = 1'b0;
      sendChar = sdi12_pkg::CH_NUL;
      case (pos[1:0])
         2'd0: bodyChar = MEAS_TEXT[27:21];
         2'd1: bodyChar = MEAS_TEXT[20:14];
         2'd2: bodyChar = MEAS_TEXT[13:7];
         default: bodyChar = MEAS_TEXT[6:0];
      endcase
      if (respKind != sdi12_pkg::RK_MEAS) begin
         bodyChar = rdData;
      end
      // reply steps
      case (respState)
         RS_IDLE: begin
            next_respCnt = '0;
            if (respGo) begin
               next_respState = RS_GAP;
            end
         end
         RS_GAP: begin
            next_respCnt = respCnt + 1'b1;
            if (respCnt == CW'(GAP_CYCLES - 1)) begin
               next_lineOe = 1'b1;
               next_respState = RS_HEAD;
            end
         end
         RS_HEAD: begin
            if (!txActive) begin
               sendReq = 1'b1;
               sendChar = myAddr;
               next_pos = '0;
               next_respState = (respKind == sdi12_pkg::RK_ACK) ? RS_CR : RS_FETCH;
            end
         end
         RS_FETCH: begin
            next_respState = RS_LOOK;
         end
         RS_LOOK: begin
            if (!txActive) begin
               if (pos == ((respKind == sdi12_pkg::RK_MEAS) ? sdi12_pkg::MEAS_LEN
                     : sdi12_pkg::REGION_LEN) || bodyChar == sdi12_pkg::CH_NUL) begin
                  next_respState = RS_CR;
               end else begin
                  sendReq = 1'b1;
                  sendChar = bodyChar;
                  next_pos = pos + 1'b1;
                  next_respState = RS_FETCH;
               end
            end
         end
         RS_CR: begin
            if (!txActive) begin
               sendReq = 1'b1;
               sendChar = sdi12_pkg::CH_CR;
               next_respState = RS_LF;
            end
         end
         RS_LF: begin
            if (!txActive) begin
               sendReq = 1'b1;
               sendChar = sdi12_pkg::CH_LF;
               next_respState = RS_DONE;
            end
         end
         RS_DONE: begin
            if (!txActive) begin
               next_lineOe = 1'b0;
               next_respState = RS_IDLE;
            end
         end
         default: begin
            next_respState = RS_IDLE;
         end
      endcase
      // frame shifter, start bit first
      if (sendReq) begin
         next_txActive = 1'b1;
         next_txShift = {1'b1, ^sendChar, sendChar, 1'b0};
         next_txBit = '0;
         next_txCnt = '0;
      end else if (txActive) begin
         next_txCnt = txCnt + 1'b1;
         if (txCnt == CW'(BIT_CYCLES - 1)) begin
            next_txCnt = '0;
            next_txShift = {1'b1, txShift[9:1]};
            next_txBit = txBit + 1'b1;
            if (txBit == 4'(sdi12_pkg::FRAME_BITS - 1)) begin
               next_txActive = 1'b0;
            end
         end
      end
      next_lineOut = next_txActive ? next_txShift[0] : 1'b1;
   end

   // reply and transmitter registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         respState <= RS_IDLE;
         respCnt <= '0;
         pos <= '0;
         txActive <= 1'b0;
         txShift <= '1;
         txBit <= '0;
         txCnt <= '0;
         lineOut <= 1'b1;
         lineOe <= 1'b0;
      end else begin
         respState <= next_respState;
         respCnt <= next_respCnt;
         pos <= next_pos;
         txActive <= next_txActive;
         txShift <= next_txShift;
         txBit <= next_txBit;
         txCnt <= next_txCnt;
         lineOut <= next_lineOut;
         lineOe <= next_lineOe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reply text memory
   sdi12_text_mem #(
      .WIDTH(7),
      .DEPTH(sdi12_pkg::MEM_DEPTH)
   ) textMem (
      .mclk(mclk),
      .arst_n(arst_n),
      .wrEn(textWrite.en),
      .wrAddr(textWrite.addr),
      .wrData(textWrite.data),
      .rdAddr(rdAddr),
      .rdData(rdData)
   );
endmodule : sdi12_sensor
`default_nettype wire

// *** verif/sdi12_sensor_checker.sv ***
// port assertions for the sdi-12 sensor end
`timescale 1ns/10ps
`default_nettype none
module sdi12_sensor_checker #(
   parameter int GAP_CYCLES = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // data wire
   input wire logic lineOut,
   input wire logic lineOe,
   // address setting
   input wire logic addrLoad,
   input wire logic [6:0] addrValue,
   // status
   input wire logic awake,
   input wire logic cmdStrobe,
   input wire logic [6:0] myAddr
);
   localparam int RISE_MIN = GAP_CYCLES;
   localparam int RISE_MAX = GAP_CYCLES + 2;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   // address characters the wire may carry
   function automatic logic legalAddr(input logic [6:0] c);
      return (c >= sdi12_pkg::CH_ZERO && c <= sdi12_pkg::CH_NINE) ||
         (c >= sdi12_pkg::CH_UA && c <= sdi12_pkg::CH_UZ) ||
         (c >= sdi12_pkg::CH_LA && c <= sdi12_pkg::CH_LZ);
   endfunction : legalAddr

   ////////////////////////////////////////////////////////////////////////////
   property p_start_low;
      $rose(lineOe) |=> (!lineOut) [*8];
   endproperty
   a_start_low: assert property (p_start_low)
      else $error("reply did not open with a start bit");
   property p_idle_mark;
      !lineOe |-> lineOut;
   endproperty
   a_idle_mark: assert property (p_idle_mark)
      else $error("released wire value not marking");
   property p_answer;
      cmdStrobe |-> ##[RISE_MIN:RISE_MAX] $rose(lineOe);
   endproperty
   a_answer: assert property (p_answer)
      else $error("accepted command got no reply after the gap");
   property p_strobe_pulse;
      cmdStrobe |=> !cmdStrobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse)
      else $error("command strobe longer than one cycle");
   property p_awake;
      (lineOe || cmdStrobe) |-> awake;
   endproperty
   a_awake: assert property (p_awake)
      else $error("sensor active while not awake");
   property p_addr_take;
      addrLoad && legalAddr(addrValue) |=> myAddr == $past(addrValue);
   endproperty
   a_addr_take: assert property (p_addr_take)
      else $error("legal address not taken");
   property p_addr_refuse;
      addrLoad && !legalAddr(addrValue) |=> $stable(myAddr);
   endproperty
   a_addr_refuse: assert property (p_addr_refuse)
      else $error("illegal address taken");
   property p_addr_legal;
      legalAddr(myAddr);
   endproperty
   a_addr_legal: assert property (p_addr_legal)
      else $error("own address outside the legal set");
   property p_stop_end;
      $fell(lineOe) |-> $past(lineOut);
   endproperty
   a_stop_end: assert property (p_stop_end)
      else $error("reply released before its stop bit");
endmodule : sdi12_sensor_checker

bind sdi12_sensor sdi12_sensor_checker #(.GAP_CYCLES(GAP_CYCLES)) u_checker (
   .mclk(mclk), .arst_n(arst_n), .lineOut(lineOut), .lineOe(lineOe), .addrLoad(addrLoad),
   .addrValue(addrValue), .awake(awake), .cmdStrobe(cmdStrobe), .myAddr(myAddr));
`default_nettype wire

// *** verif/sdi12_recorder_model.sv ***
// behavioural recorder on the far side of the data wire
`timescale 1ns/10ps
`default_nettype none
module sdi12_recorder_model #(
   parameter int BIT_CYCLES = 16
) (
   // clock
   input wire logic mclk,
   // data wire
   input wire logic lineLevel,
   output logic txLine
);
   // idle line reads marking
   initial txLine = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // one frame: start, seven data lsb first, even parity, stop
   task automatic sendChar(input logic [6:0] c);
      logic [9:0] frame;
      frame = {1'b1, ^c, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         txLine = frame[i];
         repeat (BIT_CYCLES) @(posedge mclk);
         #1;
      end
   endtask : sendChar

   // address, letter, qualifiers and bang sent whole
   task automatic sendCmd(input string s);
      byte b;
      foreach (s[i]) begin
         b = s[i];
         sendChar(b[6:0]);
      end
   endtask : sendCmd

   // wait a bounded time for a frame, sample mid bit
   task automatic getChar(output logic [6:0] c, output logic good);
      logic [9:0] bits;
      int n;
      n = 0;
      c = 7'h00;
      good = 1'b0;
      while (lineLevel !== 1'b0 && n < 1000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n < 1000) begin
         repeat (BIT_CYCLES / 2) @(posedge mclk);
         #1;
         for (int i = 0; i < 10; i++) begin
            bits[i] = lineLevel;
            if (i < 9) begin
               repeat (BIT_CYCLES) @(posedge mclk);
               #1;
            end
         end
         c = bits[7:1];
         good = !bits[0] && bits[9] && (bits[8] == ^bits[7:1]);
      end
   endtask : getChar
endmodule : sdi12_recorder_model
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the sdi-12 sensor end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int BITS = 16;
   localparam int QUIET = 2000;
   logic mclk = 1'b0;
   logic arst_n;
   logic recTx;
   wire logic lineLevel;
   logic lineOut, lineOe, awake, cmdStrobe, addrLoad;
   logic [6:0] addrValue, cmdLetter, myAddr;
   sdi12_pkg::memWrite_type textWrite;
   int err_count = 0;
   int n_tests = 0;

   // sensor owns the wire while enabled
   assign lineLevel = lineOe ? lineOut : recTx;
   always #10 mclk = ~mclk;

   sdi12_sensor #(.BIT_CYCLES(BITS), .GAP_CYCLES(8), .TIMEOUT_CYCLES(QUIET),
      .MEAS_TEXT({7'h30, 7'h31, 7'h31, 7'h30})) i_sdi12_sensor (
      .mclk(mclk), .arst_n(arst_n), .lineIn(lineLevel), .lineOut(lineOut), .lineOe(lineOe),
      .addrLoad(addrLoad), .addrValue(addrValue), .textWrite(textWrite), .awake(awake),
      .cmdStrobe(cmdStrobe), .cmdLetter(cmdLetter), .myAddr(myAddr));
   sdi12_recorder_model #(.BIT_CYCLES(BITS)) i_sdi12_recorder_model (
      .mclk(mclk), .lineLevel(lineLevel), .txLine(recTx));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   // command out, reply in, or silence when none is due
   task automatic transact(input string cmd, input string rsp, input logic reply);
      string full;
      byte b;
      logic [6:0] c;
      logic good;
      full = {rsp, "\015\012"};
      i_sdi12_recorder_model.sendCmd(cmd);
      if (!reply) begin
         i_sdi12_recorder_model.getChar(c, good);
         check(good, 1'b0);
      end else begin
         foreach (full[i]) begin
            b = full[i];
            i_sdi12_recorder_model.getChar(c, good);
            check(good, 1'b1);
            check(c, b[6:0]);
         end
         repeat (2 * BITS) @(posedge mclk);
         #1;
      end
   endtask : transact

   // reply text with its nul end mark
   task automatic putText(input logic [3:0] base, input string s);
      byte b;
      for (int i = 0; i <= s.len(); i++) begin
         b = (i < s.len()) ? s[i] : 8'h00;
         textWrite = '{en: 1'b1, addr: base + 4'(i), data: b[6:0]};
         @(posedge mclk);
         #1;
      end
      textWrite = '{en: 1'b0, addr: 4'h0, data: 7'h00};
      @(posedge mclk);
      #1;
   endtask : putText

   task automatic loadAddr(input logic [6:0] v, input logic [6:0] want);
      addrLoad = 1'b1;
      addrValue = v;
      @(posedge mclk);
      #1;
      addrLoad = 1'b0;
      @(posedge mclk);
      #1;
      check(myAddr, want);
   endtask : loadAddr

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      check(lineOut, 1'b1);
      check(lineOe, 1'b0);
      check(awake, 1'b0);
      check(cmdStrobe, 1'b0);
      check(cmdLetter, 7'h00);
      check(myAddr, 7'h30);
   endtask : test_reset

   task automatic test_measure;
      transact("0M!", "00110", 1'b1);
      check(cmdLetter, sdi12_pkg::CMD_M);
      repeat (4 * BITS) @(posedge mclk);
      #1;
      transact("0D0!", "0+5", 1'b1);
      check(cmdLetter, sdi12_pkg::CMD_D);
   endtask : test_measure

   task automatic test_foreign;
      transact("1M!", "", 1'b0);
      check(awake, 1'b1);
   endtask : test_foreign

   task automatic test_address;
      loadAddr(7'h23, 7'h30);
      loadAddr(7'h61, 7'h61);
      transact("0!", "", 1'b0);
      transact("a!", "a", 1'b1);
      check(cmdLetter, sdi12_pkg::CH_NUL);
      transact("?!", "a", 1'b1);
      transact("aI!", "aAB", 1'b1);
      check(cmdLetter, sdi12_pkg::CMD_I);
      transact("aMC!", "a", 1'b1);
   endtask : test_address

   task automatic test_sleep;
      check(awake, 1'b1);
      repeat (QUIET + 200) @(posedge mclk);
      #1;
      check(awake, 1'b0);
      transact("a!", "a", 1'b1);
   endtask : test_sleep

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // main sequence
   initial begin
      arst_n = 1'b0;
      addrLoad = 1'b0;
      addrValue = 7'h00;
      textWrite = '{en: 1'b0, addr: 4'h0, data: 7'h00};
      repeat (2) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      test_reset();
      putText(sdi12_pkg::DATA_BASE, "+5");
      putText(sdi12_pkg::IDENT_BASE, "AB");
      test_measure();
      test_foreign();
      test_address();
      test_sleep();
      // reset in mid-run brings back the default address
      arst_n = 1'b0;
      @(posedge mclk);
      #1;
      arst_n = 1'b1;
      test_reset();
      transact("0!", "0", 1'b1);
      test_done();
   end

   // watchdog
   initial begin
      #1_000_000;
      err_count++;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
